/* File: src/rbsc_pkg.sv */
// Shared constants and types for the register-based slave core
`default_nettype none
package rbsc_pkg;
	// Address modes of the operational register window
	typedef enum logic [1:0] {
		RBSC_MODE_A16 = 2'h0,
		RBSC_MODE_A24 = 2'h1,
		RBSC_MODE_A32 = 2'h2,
		RBSC_MODE_A64 = 2'h3
	} rbsc_mode_t;

	// Access space tags on the link
	typedef enum logic [1:0] {
		RBSC_SP_SHORT = 2'h0,
		RBSC_SP_24 = 2'h1,
		RBSC_SP_32 = 2'h2,
		RBSC_SP_64 = 2'h3
	} rbsc_space_t;

	// Device lifecycle states
	typedef enum logic [4:0] {
		RBSC_ST_HARD = 5'h01,
		RBSC_ST_TEST = 5'h02,
		RBSC_ST_PASS = 5'h04,
		RBSC_ST_ACTIVE = 5'h08,
		RBSC_ST_HALT = 5'h10
	} rbsc_state_t;

	// Short window layout (relative byte offsets)
	localparam logic [5:0] CFG_LAST = 6'h05;
	localparam logic [5:0] OP_A16_FIRST = 6'h06;
	localparam logic [5:0] OP_EXT_FIRST = 6'h08;
	localparam logic [5:0] OP_LAST = 6'h3F;
	localparam logic [5:0] OP_A64_GAP_LO = 6'h1C;
	localparam logic [5:0] OP_A64_GAP_HI = 6'h1D;
	localparam logic [5:0] OP_A64_RESUME = 6'h1E;
	// Configuration register offsets inside 00..05
	localparam logic [5:0] CFG_ID_OFS = 6'h00;
	localparam logic [5:0] CFG_TYPE_OFS = 6'h02;
	localparam logic [5:0] CFG_CTRL_OFS = 6'h04;
	// Control word fields
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_EXT_EN_BIT = 15;
	localparam int CTRL_HALT_BIT = 1;
	localparam int CTRL_ACT_BIT = 2;
	// Status/ID fields and "none given" codes
	localparam int SID_EXT_LSB = 16;
	localparam int SID_CAUSE_LSB = 8;
	localparam logic [15:0] SID_NO_EXT = 16'hFFFF;
	localparam logic [7:0] SID_NO_CAUSE = 8'hFF;
	// Self test length and busy threshold
	localparam int CLK_MHZ = 100;
	localparam int TEST_NS = 1000;
	localparam int TEST_CYC = TEST_NS * CLK_MHZ / 1000;
	localparam int BUSY_US = 50;
	localparam int BUSY_CYC = BUSY_US * CLK_MHZ;
	// Extended block size in address bits
	localparam int BLK_BITS = 16;
	// Identity values; arbitrary
	localparam logic [15:0] ID_VALUE = 16'h0A5C;
	localparam logic [15:0] TYPE_VALUE = 16'h7123;
endpackage
`default_nettype wire

/* File: src/rbsc_if.sv */
// Link between the commander and the register-based slave core
`default_nettype none
interface rbsc_if;
	logic req;
	logic wr;
	logic [1:0] space;
	logic [63:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic nak;
	logic [15:0] rdata;
	logic iack;
	logic irq;
	logic iack_done;
	logic [31:0] sid;
	logic sysreset;
	modport dev (
		input req, wr, space, addr, wdata, iack, sysreset,
		output ack, nak, rdata, irq, iack_done, sid
	);
	modport cmd (
		output req, wr, space, addr, wdata, iack, sysreset,
		input ack, nak, rdata, irq, iack_done, sid
	);
endinterface
`default_nettype wire

/* File: src/rbsc_decode.sv */
// Address decoder for the configuration and operational windows
`default_nettype none
module rbsc_decode (
	// Access
	input wire logic [1:0] space_i,
	input wire logic [63:0] addr_i,
	// Configuration
	input wire logic [1:0] mode_i,
	input wire logic [7:0] la_i,
	input wire logic [15:0] offset_i,
	input wire logic ext_en_i,
	// Result
	output logic cfg_o,
	output logic op_o,
	output logic ext_o,
	output logic [15:0] index_o
);
	logic [5:0] rel;
	logic short_hit;
	logic base_hit;

	// Short window is 64 bytes per logical address
	always_comb begin
		rel = addr_i[5:0];
		short_hit = (space_i == rbsc_pkg::RBSC_SP_SHORT) &&
			(addr_i[13:6] == la_i) && (addr_i[15:14] == 2'h3);
		cfg_o = 1'b0;
		op_o = 1'b0;
		ext_o = 1'b0;
		index_o = {10'h000, rel};
		if (short_hit) begin
			case (mode_i)
			rbsc_pkg::RBSC_MODE_A16: begin
				cfg_o = rel < rbsc_pkg::OP_A16_FIRST;
				op_o = !cfg_o; // [RQ5]
			end
			rbsc_pkg::RBSC_MODE_A64: begin
				// Offset word at 06 belongs to the configuration set
				cfg_o = rel < rbsc_pkg::OP_EXT_FIRST;
				op_o = (rel >= rbsc_pkg::OP_EXT_FIRST) &&
					(rel < rbsc_pkg::OP_A64_GAP_LO ||
					rel >= rbsc_pkg::OP_A64_RESUME); // [RQ8]
			end
			default: begin
				cfg_o = rel < rbsc_pkg::OP_EXT_FIRST; // Offset at 06
				op_o = rel >= rbsc_pkg::OP_EXT_FIRST; // [RQ6] [RQ7]
			end
			endcase
		end
		// Extended block placed by the offset register
		base_hit = (addr_i[31:16] == offset_i);
		if (ext_en_i && space_i != rbsc_pkg::RBSC_SP_SHORT &&
			space_i == mode_i && mode_i != rbsc_pkg::RBSC_MODE_A16) begin
			case (space_i)
			rbsc_pkg::RBSC_SP_24: ext_o = (addr_i[23:16] ==
				offset_i[15:8]) && (addr_i[63:24] == 40'h0); // [RQ6]
			rbsc_pkg::RBSC_SP_32: ext_o = base_hit &&
				(addr_i[63:32] == 32'h0); // [RQ7]
			default: ext_o = base_hit; // [RQ8]
			endcase
			if (ext_o) begin
				index_o = addr_i[15:0];
			end
		end
	end
endmodule
`default_nettype wire

/* File: src/rbsc_device.sv */
// Register-based slave core: decode, lifecycle, status/ID answer
// Overview of operation
// [RQ1] Status/ID word: extension, cause, logical address
// [RQ2] Cause and extension are device-defined, optional
// [RQ3] All ones means no cause/extension given
// [RQ4] Interrupt when long busy period ends
// [RQ5] Short-only mode: operational offsets 06..3F
// [RQ6] 24-bit mode: 08..3F plus offset block
// [RQ7] 32-bit mode: 08..3F plus offset block
// [RQ8] 64-bit mode: 08..1B, 1E..3F plus block
// [RQ9] Deactivated: no interrupt, no transfers
// [RQ10] System reset forces hard-reset state at once
// [RQ11] Reset bit set stops device operation
// [RQ12] Reset bit cleared: self test, then passed
// [RQ13] Soft reset keeps address and space assignment
// [RQ14] Non-hard termination keeps identity, offset, enable
// [RQ15] Commander restores consistency before reactivating
// [RQ16] Halt bit deactivates without self test
// [RQ17] Activate bit reactivates after soft reset
// [RQ18] Commander checks consistency after halt too
// [RQ19] Unmapped accesses are refused, not acknowledged
`default_nettype none
module rbsc_device #(
	parameter int BUSY_CYCLES = rbsc_pkg::BUSY_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Link to commander
	rbsc_if.dev link,
	// Static configuration
	input wire logic [1:0] mode_i,
	input wire logic [7:0] la_init_i,
	// Device side
	input wire logic busy_i,
	input wire logic [7:0] cause_i,
	input wire logic cause_valid_i,
	input wire logic [15:0] op_rdata_i,
	output logic op_wr_o,
	output logic [15:0] op_index_o,
	output logic [15:0] op_wdata_o,
	output logic active_o
);
	rbsc_pkg::rbsc_state_t st_q, st_d;
	logic [2:0] sync_q, sync_d;
	logic [7:0] la_q, la_d;
	logic [15:0] ofs_q, ofs_d;
	logic ext_en_q, ext_en_d, rst_bit_q, rst_bit_d;
	logic irq_en_q, irq_en_d, irq_q, irq_d, busy_q, busy_d, long_q, long_d;
	logic [12:0] bcnt_q, bcnt_d;
	logic [7:0] tcnt_q, tcnt_d;
	logic ack_q, ack_d, nak_q, nak_d, done_q, done_d, op_wr_q, op_wr_d;
	logic [15:0] rdata_q, rdata_d, idx_q, idx_d, wd_q, wd_d;
	logic [31:0] sid_q, sid_d;
	logic [1:0] in_sync_q, in_sync_d;
	logic cfg_hit, op_hit, ext_hit, strobe, iack_stb, hard;
	logic [15:0] dec_idx;
	logic [5:0] rel;

	rbsc_decode u_dec (
		.space_i(link.space),
		.addr_i(link.addr),
		.mode_i(mode_i),
		.la_i(la_q),
		.offset_i(ofs_q),
		.ext_en_i(ext_en_q),
		.cfg_o(cfg_hit),
		.op_o(op_hit),
		.ext_o(ext_hit),
		.index_o(dec_idx)
	);

	// Link strobes arrive from another board, so synchronise them
	assign strobe = sync_q[2] && !ack_q && !nak_q;
	assign iack_stb = in_sync_q[1] && !done_q;
	assign hard = link.sysreset; // Commander drives it from a flop
	assign rel = link.addr[5:0];

	// Next-state logic for lifecycle, registers and link answers
	always_comb begin
		st_d = st_q;
		sync_d = {sync_q[1], sync_q[0], link.req};
		in_sync_d = {in_sync_q[0], link.iack};
		la_d = la_q;
		ofs_d = ofs_q;
		ext_en_d = ext_en_q;
		rst_bit_d = rst_bit_q;
		irq_en_d = irq_en_q;
		irq_d = irq_q;
		busy_d = busy_i;
		long_d = long_q;
		bcnt_d = bcnt_q;
		tcnt_d = tcnt_q;
		ack_d = ack_q && sync_q[2];
		nak_d = nak_q && sync_q[2];
		done_d = done_q && in_sync_q[1];
		op_wr_d = 1'b0;
		rdata_d = rdata_q;
		idx_d = idx_q;
		wd_d = wd_q;
		sid_d = sid_q;
		// Lifecycle
		case (st_q)
		rbsc_pkg::RBSC_ST_HARD: begin
			la_d = la_init_i; // Strap caught after release
			st_d = rbsc_pkg::RBSC_ST_TEST; // [RQ10]
			tcnt_d = 8'h00;
		end
		rbsc_pkg::RBSC_ST_TEST: begin
			if (rst_bit_q) begin
				st_d = rbsc_pkg::RBSC_ST_HALT; // [RQ11]
			end else if (tcnt_q == 8'(rbsc_pkg::TEST_CYC - 1)) begin
				st_d = rbsc_pkg::RBSC_ST_PASS; // [RQ12]
			end else begin
				tcnt_d = tcnt_q + 8'h01;
			end
		end
		rbsc_pkg::RBSC_ST_PASS,
		rbsc_pkg::RBSC_ST_ACTIVE,
		rbsc_pkg::RBSC_ST_HALT: begin
			if (rst_bit_q) begin
				st_d = rbsc_pkg::RBSC_ST_HALT; // [RQ11]
			end
		end
		default: st_d = rbsc_pkg::RBSC_ST_HARD;
		endcase
		// Interrupt acknowledge; a busy end in this cycle sets irq again
		if (iack_stb && irq_q) begin
			done_d = 1'b1;
			irq_d = 1'b0;
			sid_d[7:0] = la_q; // [RQ1]
			sid_d[15:rbsc_pkg::SID_CAUSE_LSB] = cause_valid_i ?
				cause_i : rbsc_pkg::SID_NO_CAUSE; // [RQ2] [RQ3]
			sid_d[31:rbsc_pkg::SID_EXT_LSB] = rbsc_pkg::SID_NO_EXT; // [RQ3]
		end
		// Busy-period timer: only long busy spans raise interrupt
		if (busy_i && bcnt_q != 13'(BUSY_CYCLES)) begin
			bcnt_d = bcnt_q + 13'h0001;
		end else if (!busy_i) begin
			bcnt_d = 13'h0000;
		end
		if (busy_i && bcnt_q == 13'(BUSY_CYCLES)) begin
			long_d = 1'b1;
		end
		if (busy_q && !busy_i && long_q) begin
			long_d = 1'b0;
			if (irq_en_q && st_q == rbsc_pkg::RBSC_ST_ACTIVE) begin
				irq_d = 1'b1; // [RQ4]
			end
		end
		// Register access
		if (strobe) begin
			if (cfg_hit) begin
				ack_d = 1'b1;
				rdata_d = 16'h0000;
				case (rel & 6'h3E)
				rbsc_pkg::CFG_ID_OFS: rdata_d = rbsc_pkg::ID_VALUE;
				rbsc_pkg::CFG_TYPE_OFS: rdata_d = rbsc_pkg::TYPE_VALUE;
				rbsc_pkg::CFG_CTRL_OFS: begin
					rdata_d[rbsc_pkg::CTRL_RESET_BIT] = rst_bit_q;
					rdata_d[rbsc_pkg::CTRL_EXT_EN_BIT] = ext_en_q;
					rdata_d[rbsc_pkg::CTRL_ACT_BIT] =
						st_q == rbsc_pkg::RBSC_ST_ACTIVE;
					rdata_d[rbsc_pkg::CTRL_HALT_BIT] =
						st_q == rbsc_pkg::RBSC_ST_HALT;
					if (link.wr) begin
						rst_bit_d = link.wdata[rbsc_pkg::CTRL_RESET_BIT];
						ext_en_d = link.wdata[rbsc_pkg::CTRL_EXT_EN_BIT];
						// Clearing reset restarts self test
						if (rst_bit_q && !rst_bit_d) begin
							st_d = rbsc_pkg::RBSC_ST_TEST; // [RQ12]
							tcnt_d = 8'h00;
						end else if (!rst_bit_d &&
							link.wdata[rbsc_pkg::CTRL_HALT_BIT]) begin
							st_d = rbsc_pkg::RBSC_ST_HALT; // [RQ16]
						end else if (!rst_bit_d &&
							link.wdata[rbsc_pkg::CTRL_ACT_BIT] &&
							st_q != rbsc_pkg::RBSC_ST_TEST) begin
							st_d = rbsc_pkg::RBSC_ST_ACTIVE; // [RQ17]
						end
						irq_en_d = link.wdata[rbsc_pkg::CTRL_ACT_BIT + 1];
					end
				end
				default: begin
					rdata_d = ofs_q; // Offset word at 06 in cfg range
					if (link.wr) begin
						ofs_d = link.wdata;
					end
				end
				endcase
			end else if ((op_hit || ext_hit) &&
				st_q == rbsc_pkg::RBSC_ST_ACTIVE) begin
				ack_d = 1'b1;
				idx_d = dec_idx;
				wd_d = link.wdata;
				op_wr_d = link.wr;
				rdata_d = op_rdata_i;
			end else begin
				nak_d = 1'b1; // [RQ19]
			end
		end
		// Deactivated devices drop interrupt requests
		if (st_d != rbsc_pkg::RBSC_ST_ACTIVE) begin
			irq_d = 1'b0; // [RQ9]
		end
		// Soft paths never touch la, offset, enable
		if (hard) begin
			st_d = rbsc_pkg::RBSC_ST_HARD; // [RQ10] [RQ13] [RQ14]
			ext_en_d = 1'b0;
			rst_bit_d = 1'b0;
		end
	end

	// Registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= rbsc_pkg::RBSC_ST_HARD; // [RQ10]
			sync_q <= 3'h0;
			in_sync_q <= 2'h0;
			la_q <= 8'hFF;
			ofs_q <= 16'h0000;
			ext_en_q <= 1'b0;
			rst_bit_q <= 1'b0;
			irq_en_q <= 1'b0;
			irq_q <= 1'b0;
			busy_q <= 1'b0;
			long_q <= 1'b0;
			bcnt_q <= 13'h0000;
			tcnt_q <= 8'h00;
			ack_q <= 1'b0;
			nak_q <= 1'b0;
			done_q <= 1'b0;
			op_wr_q <= 1'b0;
			rdata_q <= 16'h0000;
			idx_q <= 16'h0000;
			wd_q <= 16'h0000;
			sid_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			sync_q <= sync_d;
			in_sync_q <= in_sync_d;
			la_q <= la_d;
			ofs_q <= ofs_d;
			ext_en_q <= ext_en_d;
			rst_bit_q <= rst_bit_d;
			irq_en_q <= irq_en_d;
			irq_q <= irq_d;
			busy_q <= busy_d;
			long_q <= long_d;
			bcnt_q <= bcnt_d;
			tcnt_q <= tcnt_d;
			ack_q <= ack_d;
			nak_q <= nak_d;
			done_q <= done_d;
			op_wr_q <= op_wr_d;
			rdata_q <= rdata_d;
			idx_q <= idx_d;
			wd_q <= wd_d;
			sid_q <= sid_d;
		end
	end

	// Outputs straight from flip-flops, except active_o, which is decoded from st_q
	assign link.ack = ack_q;
	assign link.nak = nak_q;
	assign link.rdata = rdata_q;
	assign link.irq = irq_q;
	assign link.iack_done = done_q;
	assign link.sid = sid_q;
	assign op_wr_o = op_wr_q;
	assign op_index_o = idx_q;
	assign op_wdata_o = wd_q;
	assign active_o = st_q == rbsc_pkg::RBSC_ST_ACTIVE;
endmodule
`default_nettype wire

/* File: src/rbsc_commander.sv */
// Commander end: runs single accesses and interrupt acknowledges
`default_nettype none
module rbsc_commander (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Link to device
	rbsc_if.cmd link,
	// User request
	input wire logic start_i,
	input wire logic wr_i,
	input wire logic [1:0] space_i,
	input wire logic [63:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic sysreset_i,
	output logic busy_o,
	output logic done_o,
	output logic err_o,
	output logic [15:0] rdata_o,
	output logic irq_o,
	output logic sid_valid_o,
	output logic [31:0] sid_o
);
	typedef enum logic [2:0] {
		RBSC_C_IDLE = 3'h1,
		RBSC_C_REQ = 3'h2,
		RBSC_C_DROP = 3'h4
	} rbsc_cst_t;
	rbsc_cst_t st_q, st_d;
	logic req_q, req_d, wr_q, wr_d, iack_q, iack_d, rst_q, rst_d;
	logic [1:0] sp_q, sp_d;
	logic [63:0] ad_q, ad_d;
	logic [15:0] wd_q, wd_d, rd_q, rd_d;
	logic done_q, done_d, err_q, err_d, sv_q, sv_d;
	logic [31:0] sid_q, sid_d;
	logic [1:0] ans_q, irq_s_q;
	logic [1:0] ans_d, irq_s_d;

	// Request/answer handshake; answers come from a far board
	always_comb begin
		st_d = st_q;
		req_d = req_q;
		wr_d = wr_q;
		sp_d = sp_q;
		ad_d = ad_q;
		wd_d = wd_q;
		rd_d = rd_q;
		iack_d = iack_q;
		rst_d = sysreset_i;
		done_d = 1'b0;
		err_d = 1'b0;
		sv_d = 1'b0;
		sid_d = sid_q;
		ans_d = {ans_q[0], link.ack | link.nak};
		irq_s_d = {irq_s_q[0], link.irq};
		case (st_q)
		RBSC_C_IDLE: begin
			if (start_i) begin
				req_d = 1'b1;
				wr_d = wr_i;
				sp_d = space_i;
				ad_d = addr_i;
				wd_d = wdata_i;
				st_d = RBSC_C_REQ;
			end else if (irq_s_q[1]) begin
				iack_d = 1'b1;
				st_d = RBSC_C_REQ;
			end
		end
		RBSC_C_REQ: begin
			if (req_q && ans_q[1]) begin
				req_d = 1'b0;
				rd_d = link.rdata;
				err_d = link.nak;
				done_d = 1'b1;
				st_d = RBSC_C_DROP;
			end else if (iack_q && link.iack_done) begin
				iack_d = 1'b0;
				sid_d = link.sid;
				sv_d = 1'b1;
				st_d = RBSC_C_DROP;
			end else if (iack_q && !irq_s_q[1]) begin
				iack_d = 1'b0;
				st_d = RBSC_C_DROP;
			end
		end
		RBSC_C_DROP: begin
			// Wait for the device to release its answer
			if (!ans_q[1] && !link.iack_done) begin
				st_d = RBSC_C_IDLE;
			end
		end
		default: st_d = RBSC_C_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= RBSC_C_IDLE;
			req_q <= 1'b0;
			wr_q <= 1'b0;
			sp_q <= 2'h0;
			ad_q <= 64'h0;
			wd_q <= 16'h0000;
			rd_q <= 16'h0000;
			iack_q <= 1'b0;
			rst_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			sv_q <= 1'b0;
			sid_q <= 32'h0000_0000;
			ans_q <= 2'h0;
			irq_s_q <= 2'h0;
		end else begin
			st_q <= st_d;
			req_q <= req_d;
			wr_q <= wr_d;
			sp_q <= sp_d;
			ad_q <= ad_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			iack_q <= iack_d;
			rst_q <= rst_d;
			done_q <= done_d;
			err_q <= err_d;
			sv_q <= sv_d;
			sid_q <= sid_d;
			ans_q <= ans_d;
			irq_s_q <= irq_s_d;
		end
	end

	assign link.req = req_q;
	assign link.wr = wr_q;
	assign link.space = sp_q;
	assign link.addr = ad_q;
	assign link.wdata = wd_q;
	assign link.iack = iack_q;
	assign link.sysreset = rst_q;
	assign busy_o = st_q != RBSC_C_IDLE;
	assign done_o = done_q;
	assign err_o = err_q;
	assign rdata_o = rd_q;
	assign irq_o = irq_s_q[1];
	assign sid_valid_o = sv_q;
	assign sid_o = sid_q;
endmodule
`default_nettype wire

/* File: tb/rbsc_props.sv */
// Link checker for the register-based slave core pair
`default_nettype none
module rbsc_props #(
	parameter logic [7:0] LA = 8'h00,
	parameter logic [1:0] MODE = 2'h3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Link signals
	input wire logic req,
	input wire logic [1:0] space,
	input wire logic [63:0] addr,
	input wire logic ack,
	input wire logic nak,
	input wire logic [15:0] rdata,
	input wire logic iack,
	input wire logic irq,
	input wire logic iack_done,
	input wire logic [31:0] sid,
	input wire logic sysreset
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Short window of this device
	logic hit;
	assign hit = space == 2'h0 && addr[15:14] == 2'h3 && addr[13:6] == LA;

	// Answers
	answer_excl_a: assert property (!(ack && nak))
		else $error("ack and nak together");
	answer_due_a: assert property ($rose(req) |-> ##[1:6] (ack || nak))
		else $error("request left unanswered");
	answer_held_a: assert property (ack && req |=> ack)
		else $error("ack dropped while request held");
	answer_drop_a: assert property ($fell(req) |-> ##[1:5] !(ack || nak))
		else $error("answer outlived request");
	rdata_steady_a: assert property (ack && $past(ack) |-> $stable(rdata))
		else $error("read data moved under ack");
	// Decode
	cfg_taken_a: assert property (req && hit && addr[5:0] <= 6'h05 |-> ##[0:6] ack)
		else $error("configuration access not acked");
	gap_refused_a: assert property (req && hit && MODE == 2'h3 && addr[5:1] == 5'h0E |-> !ack)
		else $error("gap offset acked");
	foreign_la_a: assert property (req && space == 2'h0 && addr[13:6] != LA |-> !ack)
		else $error("other address acked");
	// Interrupt acknowledge and irq during system reset
	iack_due_a: assert property ($rose(iack) |-> ##[1:6] iack_done)
		else $error("interrupt acknowledge unanswered");
	sid_ext_a: assert property (iack_done |-> sid[31:16] == 16'hFFFF)
		else $error("extension not all ones");
	irq_clear_a: assert property ($rose(iack_done) |-> ##[0:3] !irq)
		else $error("irq kept after answer");
	hard_quiet_a: assert property (sysreset |-> ##[1:6] !irq)
		else $error("irq during system reset");
endmodule
`default_nettype wire

/* File: tb/register_based_slave_core_tb.sv */
// Self-checking bench for the commander and device pair
`default_nettype none
module register_based_slave_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] LA = 8'h2A;
	localparam logic [15:0] OFS = 16'h1234;
	localparam int BUSY = 20;
	localparam logic [63:0] EXT = {32'h0, OFS, 16'h0010};
	logic clk_i, reset_n_i, start_i, wr_i, sysreset_i;
	logic [1:0] space_i;
	logic [63:0] addr_i;
	logic [15:0] wdata_i, rdata_o, op_rdata_i, op_index_o, op_wdata_o;
	logic busy_o, done_o, err_o, irq_o, sid_valid_o, op_wr_o, active_o;
	logic [31:0] sid_o;
	logic busy_i, cause_valid_i;
	logic [7:0] cause_i;
	int mismatches, check_count, cycles, wr_pulses;
	logic [5:0] offs [6] = '{6'h08, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h3F};
	logic nk [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

	rbsc_if lnk();
	rbsc_device #(.BUSY_CYCLES(BUSY)) u_rbsc_device (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .link(lnk), .mode_i(rbsc_pkg::RBSC_MODE_A64),
		.la_init_i(LA), .busy_i(busy_i), .cause_i(cause_i),
		.cause_valid_i(cause_valid_i), .op_rdata_i(op_rdata_i),
		.op_wr_o(op_wr_o), .op_index_o(op_index_o),
		.op_wdata_o(op_wdata_o), .active_o(active_o));
	rbsc_commander u_rbsc_commander (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link(lnk), .start_i(start_i), .wr_i(wr_i), .space_i(space_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .sysreset_i(sysreset_i),
		.busy_o(busy_o), .done_o(done_o), .err_o(err_o), .rdata_o(rdata_o),
		.irq_o(irq_o), .sid_valid_o(sid_valid_o), .sid_o(sid_o));
	rbsc_props #(.LA(LA), .MODE(2'h3)) u_rbsc_props (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .req(lnk.req), .space(lnk.space),
		.addr(lnk.addr), .ack(lnk.ack), .nak(lnk.nak), .rdata(lnk.rdata),
		.iack(lnk.iack), .irq(lnk.irq), .iack_done(lnk.iack_done),
		.sid(lnk.sid), .sysreset(lnk.sysreset));

	// Free-running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Hang guard; normal run is near 1100 cycles
	always @(posedge clk_i) begin
		cycles++;
		// Count write strobes toward the operational registers
		if (op_wr_o === 1'b1)
			wr_pulses++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [63:0] sa(input logic [7:0] la, input logic [5:0] o);
		return {48'h0, 2'h3, la, o};
	endfunction

	// One access; error or done ends it, then wait for idle
	task automatic ex(input string nm, input logic w, input logic [1:0] s,
		input logic [63:0] a, input logic [15:0] d, input logic ee,
		input logic [15:0] eq);
		logic e;
		@(negedge clk_i);
		wr_i = w;
		space_i = s;
		addr_i = a;
		wdata_i = d;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		e = 1'bx;
		for (int i = 0; i < 40; i++) begin
			if (done_o === 1'b1 || err_o === 1'b1) begin
				e = err_o;
				break;
			end
			@(negedge clk_i);
		end
		chk(nm, ee, e);
		if (!w && !ee)
			chk(nm, eq, rdata_o);
		for (int i = 0; i < 20 && busy_o !== 1'b0; i++) @(negedge clk_i);
	endtask

	// Long busy period, then watch for the status/ID answer
	task automatic busy_run(input logic ei, input logic [7:0] ec);
		logic seen, rq;
		seen = 1'b0;
		rq = 1'b0;
		busy_i = 1'b1;
		repeat (BUSY + 10) @(negedge clk_i);
		busy_i = 1'b0;
		for (int i = 0; i < 60; i++) begin
			@(negedge clk_i);
			if (irq_o === 1'b1)
				rq = 1'b1;
			if (sid_valid_o === 1'b1) begin
				seen = 1'b1;
				chk("sid", {16'hFFFF, ec, LA}, sid_o);
			end
		end
		chk("irq seen", ei, seen);
		chk("irq_o", ei, rq);
	endtask

	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask

	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		start_i = 1'b0;
		wr_i = 1'b0;
		sysreset_i = 1'b0;
		space_i = 2'h0;
		addr_i = 64'h0;
		wdata_i = 16'h0;
		busy_i = 1'b0;
		cause_i = 8'h00;
		cause_valid_i = 1'b0;
		op_rdata_i = 16'hBEEF;
		repeat (6) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (120) @(negedge clk_i);
		ex("id", 0, 0, sa(LA, 6'h00), 0, 0, rbsc_pkg::ID_VALUE);
		ex("type", 0, 0, sa(LA, 6'h02), 0, 0, rbsc_pkg::TYPE_VALUE);
		ex("op idle", 0, 0, sa(LA, 6'h08), 0, 1, 0);
		chk("active", 0, active_o);
		ex("ofs wr", 1, 0, sa(LA, 6'h06), OFS, 0, 0);
		ex("ctrl", 1, 0, sa(LA, 6'h04), 16'h800C, 0, 0);
		chk("active", 1, active_o);
		fin("config");
		for (int i = 0; i < 6; i++)
			ex("op", 0, 0, sa(LA, offs[i]), 0, nk[i], 16'hBEEF);
		ex("op wr", 1, 0, sa(LA, 6'h1E), 16'h5A5A, 0, 0);
		chk("op wr", 1, wr_pulses);
		chk("op idx", 16'h001E, op_index_o);
		chk("op wd", 16'h5A5A, op_wdata_o);
		ex("other la", 0, 0, sa(LA + 8'h01, 6'h08), 0, 1, 0);
		ex("ext", 0, 3, EXT, 0, 0, 16'hBEEF);
		chk("ext idx", 16'h0010, op_index_o);
		ex("ext space", 0, 2, EXT, 0, 1, 0);
		ex("ext ofs", 0, 3, EXT ^ 64'h10000, 0, 1, 0);
		fin("window");
		busy_run(1, 8'hFF);
		cause_i = 8'h5A;
		cause_valid_i = 1'b1;
		busy_run(1, 8'h5A);
		cause_valid_i = 1'b0;
		fin("irq");
		ex("halt", 1, 0, sa(LA, 6'h04), 16'h800A, 0, 0);
		chk("active", 0, active_o);
		ex("op halted", 0, 0, sa(LA, 6'h08), 0, 1, 0);
		busy_run(0, 8'hFF);
		ex("ofs kept", 0, 0, sa(LA, 6'h06), 0, 0, OFS);
		ex("react", 1, 0, sa(LA, 6'h04), 16'h800C, 0, 0);
		chk("active", 1, active_o);
		fin("halt");
		ex("soft", 1, 0, sa(LA, 6'h04), 16'h8009, 0, 0);
		chk("active", 0, active_o);
		ex("op soft", 0, 0, sa(LA, 6'h08), 0, 1, 0);
		ex("soft off", 1, 0, sa(LA, 6'h04), 16'h8008, 0, 0);
		repeat (120) @(negedge clk_i);
		chk("active", 0, active_o);
		ex("ofs soft", 0, 0, sa(LA, 6'h06), 0, 0, OFS);
		ex("react", 1, 0, sa(LA, 6'h04), 16'h800C, 0, 0);
		ex("ext soft", 0, 3, EXT, 0, 0, 16'hBEEF);
		fin("soft");
		sysreset_i = 1'b1;
		repeat (5) @(negedge clk_i);
		chk("active", 0, active_o);
		sysreset_i = 1'b0;
		repeat (120) @(negedge clk_i);
		ex("act", 1, 0, sa(LA, 6'h04), 16'h0004, 0, 0);
		ex("ext hard", 0, 3, EXT, 0, 1, 0);
		ex("op hard", 0, 0, sa(LA, 6'h3F), 0, 0, 16'hBEEF);
		fin("hard");
		wrap_up();
	end
endmodule
`default_nettype wire
